// *** rtl/srcb_cfg.svh ***
// Register map, field positions, reset values and timing counts
`ifndef SRCB_CFG_SVH
`define SRCB_CFG_SVH

`define SRCB_ADDR_W 7
`define SRCB_A_OPMODE 7'h01
`define SRCB_A_DATAMOD 7'h02
`define SRCB_A_BR_HI 7'h03
`define SRCB_A_BR_LO 7'h04
`define SRCB_A_FRF_HI 7'h07
`define SRCB_A_FRF_MID 7'h08
`define SRCB_A_FRF_LO 7'h09
`define SRCB_A_PINMAP2 7'h26
`define SRCB_A_EXTREF 7'h59

`define SRCB_EXTREF_BIT 4
`define SRCB_OPM_SEQ_OFF_BIT 7
`define SRCB_OPM_MODE_HI 4
`define SRCB_OPM_MODE_LO 2
`define SRCB_DM_CONT_BIT 6
`define SRCB_DM_SHAPE_HI 1
`define SRCB_DM_SHAPE_LO 0
`define SRCB_PM2_SEL_HI 2
`define SRCB_PM2_SEL_LO 0

`define SRCB_MODE_SLEEP 3'h0
`define SRCB_MODE_STDBY 3'h1
`define SRCB_MODE_FS 3'h2
`define SRCB_MODE_TX 3'h3
`define SRCB_MODE_RX 3'h4
`define SRCB_REFSEL_OFF 3'h7

`define SRCB_RST_OPMODE 8'h04
`define SRCB_RST_DATAMOD 8'h00
`define SRCB_RST_BR 16'h1A0B
`define SRCB_RST_FRF 24'h800000
`define SRCB_RST_PINMAP2 8'h00
`define SRCB_RST_EXTREF 8'h00
`define SRCB_BR_MIN 16'h0002
`define SRCB_SD_BITS 19

`define SRCB_CLK_NS 40
`define SRCB_OSC_NS 2000
`define SRCB_COARSE_NS 400
`define SRCB_FINE_NS 200
`define SRCB_LOCK_NS 400
`define SRCB_OSC_CYC ((`SRCB_OSC_NS + `SRCB_CLK_NS - 1) / `SRCB_CLK_NS)
`define SRCB_COARSE_CYC ((`SRCB_COARSE_NS + `SRCB_CLK_NS - 1) / `SRCB_CLK_NS)
`define SRCB_FINE_CYC ((`SRCB_FINE_NS + `SRCB_CLK_NS - 1) / `SRCB_CLK_NS)
`define SRCB_LOCK_CYC ((`SRCB_LOCK_NS + `SRCB_CLK_NS - 1) / `SRCB_CLK_NS)
`define SRCB_WR_GAP 4'h6

`endif

// *** rtl/srcb_pkg.sv ***
// Types shared by both ends of the synthesizer control link
`include "srcb_cfg.svh"
package srcb_pkg;
  typedef enum logic [1:0] {PLL_OFF, PLL_CAL, PLL_LOCKING, PLL_LOCKED} srcb_pll_type;
endpackage

// *** rtl/srcb_if.sv ***
// Pin bundle between the radio device and its host controller
`timescale 1ns/1ps
`default_nettype none
`include "srcb_cfg.svh"
interface srcb_if;
  logic general_pin_five;
  logic lock_pin;
  logic bit_clock_pin;
  logic serial_tx_data_pin;
  logic reg_wr_toggle;
  logic [`SRCB_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_data;
  modport dev_mp (
    output general_pin_five, lock_pin, bit_clock_pin,
    input serial_tx_data_pin, reg_wr_toggle, reg_addr, reg_data
  );
  modport host_mp (
    input general_pin_five, lock_pin, bit_clock_pin,
    output serial_tx_data_pin, reg_wr_toggle, reg_addr, reg_data
  );
endinterface
`default_nettype wire

// *** rtl/srcb_buf2.sv ***
// Small valid/ready buffer, two entries by default
`timescale 1ns/1ps
`default_nettype none
module srcb_buf2 #(
  parameter int W = 1,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,           // System clock
  input wire logic i_rst,           // Async reset, high
  input wire logic i_valid,         // Fill side valid
  input wire logic [W-1:0] i_data,  // Fill side data
  output logic o_ready,             // Fill side ready
  output logic o_valid,             // Drain side valid
  output logic [W-1:0] o_data,      // Drain side data
  input wire logic i_ready          // Drain side ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } srcb_buf_state_type;
  srcb_buf_state_type r, n;
  logic push, pop;

  assign o_ready = (r.cnt != (PW+1)'(DEPTH));
  assign o_valid = (r.cnt != '0);
  assign o_data = r.mem[r.rp];

  always_comb begin
    n = r;
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    if (push) begin
      n.mem[r.wp] = i_data;
      n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : PW'(r.wp + 1'b1);
    end
    if (pop) begin
      n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : PW'(r.rp + 1'b1);
    end
    if (push && !pop) begin
      n.cnt = (PW+1)'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      n.cnt = (PW+1)'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// *** rtl/srcb_device.sv ***
// Radio end: reference clock, synthesizer sequencing and bit-rate clock
//
// Notes on behaviour
// - Sequencer starts PLL once coarse calibration is done
// - Reference output held off until oscillator stable
// - Host waits oscillator time or reference edge
// - External reference chosen by bit four, 0x59
// - Reference divided by two to 128 driven on pin five
// - Reference output on after reset, stopped in Sleep
// - Coarse calibration at reset, fine per PLL start
// - Step is reference over two to nineteen
// - Carrier is step times 24-bit word
// - New carrier word applies on low byte
// - Sequencer enables radio once PLL locked
// - Host waits lock time or lock flag
// - Lock flag high in range, low otherwise
// - Lock flag may drop during wide FSK
// - Plain continuous mode passes data straight through
// - Shaped continuous mode drives bit clock
// - Bit rate is reference over 16-bit divisor
`timescale 1ns/1ps
`default_nettype none
`include "srcb_cfg.svh"
module srcb_device #(
  parameter int OSC_CYC = `SRCB_OSC_CYC,
  parameter int COARSE_CYC = `SRCB_COARSE_CYC,
  parameter int FINE_CYC = `SRCB_FINE_CYC,
  parameter int LOCK_CYC = `SRCB_LOCK_CYC
) (
  input wire logic i_clk,             // Crystal reference clock
  input wire logic i_rst,             // Power-on reset, async high
  srcb_if.dev_mp ifc,                 // Pins toward the host
  output logic [23:0] o_carrier_word, // Active carrier word
  output logic o_ext_ref,             // External reference selected
  output logic o_coarse_done,         // Coarse calibration finished
  output logic o_pll_lock,            // PLL in locked state
  output logic o_tx_on,               // Transmitter enabled
  output logic o_rx_on,               // Receiver enabled
  output logic o_mod_bit,             // Bit fed to the modulator
  output logic o_bit_tick             // One pulse per bit period
);
  import srcb_pkg::*;

  typedef struct packed {
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [`SRCB_ADDR_W-1:0] addr_s1;
    logic [`SRCB_ADDR_W-1:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic txd_s1;
    logic txd_s2;
    logic [7:0] opmode;
    logic [7:0] datamod;
    logic [15:0] br;
    logic [7:0] frf_hi;
    logic [7:0] frf_mid;
    logic [7:0] frf_lo;
    logic commit_pend;
    logic [23:0] frf_act;
    logic [7:0] pinmap2;
    logic [7:0] extref;
    logic [15:0] por_cnt;
    logic osc_ok;
    logic coarse_done;
    srcb_pll_type pll;
    logic [15:0] pll_cnt;
    logic tx_on;
    logic rx_on;
    logic [7:0] ref_div;
    logic ref_out;
    logic [15:0] br_cnt;
    logic [15:0] br_per;
    logic bclk;
    logic bit_tick;
    logic mod_bit;
  } srcb_dev_state_type;

  localparam int POR_END = OSC_CYC + COARSE_CYC;
  localparam srcb_dev_state_type RST = '{
    opmode: `SRCB_RST_OPMODE,
    datamod: `SRCB_RST_DATAMOD,
    br: `SRCB_RST_BR,
    frf_hi: 8'(`SRCB_RST_FRF >> 16),
    frf_mid: 8'(`SRCB_RST_FRF >> 8),
    frf_lo: 8'(`SRCB_RST_FRF),
    frf_act: `SRCB_RST_FRF,
    pinmap2: `SRCB_RST_PINMAP2,
    extref: `SRCB_RST_EXTREF,
    br_per: `SRCB_BR_MIN,
    pll: PLL_OFF,
    default: '0
  };

  srcb_dev_state_type r, n;
  logic wr_ev;
  logic [2:0] mode;
  logic seq_on;
  logic pll_req;
  logic [2:0] ref_sel;
  logic cont_mode;
  logic shaped;
  logic sync_tx;

  always_comb begin
    n = r;
    n.wr_s1 = ifc.reg_wr_toggle;
    n.wr_s2 = r.wr_s1;
    n.wr_s3 = r.wr_s2;
    n.addr_s1 = ifc.reg_addr;
    n.addr_s2 = r.addr_s1;
    n.data_s1 = ifc.reg_data;
    n.data_s2 = r.data_s1;
    n.txd_s1 = ifc.serial_tx_data_pin;
    n.txd_s2 = r.txd_s1;
    wr_ev = r.wr_s2 ^ r.wr_s3;
    mode = r.opmode[`SRCB_OPM_MODE_HI:`SRCB_OPM_MODE_LO];
    seq_on = !r.opmode[`SRCB_OPM_SEQ_OFF_BIT];
    pll_req = (mode == `SRCB_MODE_FS) || (mode == `SRCB_MODE_TX) || (mode == `SRCB_MODE_RX);
    ref_sel = r.pinmap2[`SRCB_PM2_SEL_HI:`SRCB_PM2_SEL_LO];
    cont_mode = r.datamod[`SRCB_DM_CONT_BIT];
    shaped = (r.datamod[`SRCB_DM_SHAPE_HI:`SRCB_DM_SHAPE_LO] != 2'h0);
    sync_tx = cont_mode && shaped;

    n.commit_pend = 1'b0;
    if (r.commit_pend) begin
      n.frf_act = {r.frf_hi, r.frf_mid, r.frf_lo};
    end

    // Register writes from the host pins
    if (wr_ev) begin
      case (r.addr_s2)
        `SRCB_A_OPMODE: n.opmode = r.data_s2;
        `SRCB_A_DATAMOD: n.datamod = r.data_s2;
        `SRCB_A_BR_HI: n.br[15:8] = r.data_s2;
        `SRCB_A_BR_LO: n.br[7:0] = r.data_s2;
        `SRCB_A_FRF_HI: n.frf_hi = r.data_s2;
        `SRCB_A_FRF_MID: n.frf_mid = r.data_s2;
        `SRCB_A_FRF_LO: begin
          n.frf_lo = r.data_s2;
          n.commit_pend = 1'b1;
        end
        `SRCB_A_PINMAP2: n.pinmap2 = r.data_s2;
        `SRCB_A_EXTREF: n.extref = r.data_s2;
        default: ;
      endcase
    end

    if (r.por_cnt != 16'(POR_END)) begin
      n.por_cnt = 16'(r.por_cnt + 1'b1);
    end
    n.osc_ok = (n.por_cnt >= 16'(OSC_CYC));
    n.coarse_done = (n.por_cnt == 16'(POR_END));

    n.pll_cnt = 16'(r.pll_cnt + 1'b1);
    unique case (r.pll)
      PLL_OFF: begin
        n.pll_cnt = '0;
        if (pll_req && r.coarse_done) begin
          n.pll = PLL_CAL;
        end
      end
      PLL_CAL: begin
        if (r.pll_cnt == 16'(FINE_CYC - 1)) begin
          n.pll = PLL_LOCKING;
          n.pll_cnt = '0;
        end
      end
      PLL_LOCKING: begin
        if (r.pll_cnt == 16'(LOCK_CYC - 1)) begin
          n.pll = PLL_LOCKED;
          n.pll_cnt = '0;
        end
      end
      PLL_LOCKED: begin
        n.pll_cnt = '0;
        if (r.commit_pend) begin
          n.pll = PLL_LOCKING;
        end
      end
    endcase
    if (!pll_req) begin
      n.pll = PLL_OFF;
    end

    // radio waits for lock under sequencer
    n.tx_on = (mode == `SRCB_MODE_TX) && (!seq_on || n.pll == PLL_LOCKED);
    n.rx_on = (mode == `SRCB_MODE_RX) && (!seq_on || n.pll == PLL_LOCKED);

    n.ref_div = 8'(r.ref_div + 1'b1);
    if (r.osc_ok && mode != `SRCB_MODE_SLEEP && ref_sel != `SRCB_REFSEL_OFF) begin
      n.ref_out = r.ref_div[ref_sel];
    end else begin
      n.ref_out = 1'b0;
    end

    n.bit_tick = 1'b0;
    if (r.br_cnt >= 16'(r.br_per - 1'b1)) begin
      n.br_cnt = '0;
      n.br_per = (r.br < `SRCB_BR_MIN) ? `SRCB_BR_MIN : r.br;
      n.bit_tick = 1'b1;
    end else begin
      n.br_cnt = 16'(r.br_cnt + 1'b1);
    end
    // bit clock high in first half
    n.bclk = sync_tx && (n.br_cnt < (n.br_per >> 1));

    if (cont_mode && !shaped) begin
      n.mod_bit = r.txd_s2;
    end else if (sync_tx && r.bclk && !n.bclk) begin
      n.mod_bit = r.txd_s2;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // step fixed by the modulator width
  assign o_carrier_word = r.frf_act;
  assign o_ext_ref = r.extref[`SRCB_EXTREF_BIT];
  assign o_coarse_done = r.coarse_done;
  assign o_pll_lock = (r.pll == PLL_LOCKED);
  assign o_tx_on = r.tx_on;
  assign o_rx_on = r.rx_on;
  assign o_mod_bit = r.mod_bit;
  assign o_bit_tick = r.bit_tick;
  assign ifc.general_pin_five = r.ref_out;
  // lock pin follows lock state only
  assign ifc.lock_pin = (r.pll == PLL_LOCKED);
  assign ifc.bit_clock_pin = r.bclk;
endmodule
`default_nettype wire

// *** rtl/srcb_host.sv ***
// Host end: register writes, start-up watch and transmit bit feed
`timescale 1ns/1ps
`default_nettype none
`include "srcb_cfg.svh"
module srcb_host (
  input wire logic i_clk,                     // Host clock
  input wire logic i_rst,                     // Async reset, high
  srcb_if.host_mp ifc,                        // Pins toward the device
  input wire logic i_wr_valid,                // Register write request
  input wire logic [`SRCB_ADDR_W-1:0] i_wr_addr, // Register address
  input wire logic [7:0] i_wr_data,           // Register data
  output logic o_wr_ready,                    // Write may be taken
  input wire logic i_bit_valid,               // Transmit bit offered
  input wire logic i_bit,                     // Transmit bit value
  output logic o_bit_ready,                   // Transmit bit taken
  input wire logic i_sync_tx,                 // Device runs shaped stream
  output logic o_osc_ready,                   // Reference output seen
  output logic o_pll_locked                   // Lock pin, synchronised
);
  import srcb_pkg::*;

  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic lock_s1;
    logic lock_s2;
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_s3;
    logic osc_seen;
    logic wr_tgl;
    logic [`SRCB_ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [3:0] gap;
    logic txd;
  } srcb_host_state_type;

  srcb_host_state_type r, n;
  logic pop;
  logic buf_valid;
  logic buf_bit;

  srcb_buf2 #(.W(1), .DEPTH(2)) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_bit_valid),
    .i_data(i_bit),
    .o_ready(o_bit_ready),
    .o_valid(buf_valid),
    .o_data(buf_bit),
    .i_ready(pop)
  );

  always_comb begin
    n = r;
    n.ref_s1 = ifc.general_pin_five;
    n.ref_s2 = r.ref_s1;
    n.ref_s3 = r.ref_s2;
    n.lock_s1 = ifc.lock_pin;
    n.lock_s2 = r.lock_s1;
    n.bclk_s1 = ifc.bit_clock_pin;
    n.bclk_s2 = r.bclk_s1;
    n.bclk_s3 = r.bclk_s2;
    // first reference edge marks oscillator ready
    if (r.ref_s2 && !r.ref_s3) begin
      n.osc_seen = 1'b1;
    end
    // Toggle handshake, fields held through the gap
    if (i_wr_valid && r.gap == 4'h0) begin
      n.addr = i_wr_addr;
      n.data = i_wr_data;
      n.wr_tgl = !r.wr_tgl;
      n.gap = `SRCB_WR_GAP;
    end else if (r.gap != 4'h0) begin
      n.gap = 4'(r.gap - 1'b1);
    end
    // next bit on each bit clock rise with i_sync_tx, else every cycle
    pop = i_sync_tx ? (r.bclk_s2 && !r.bclk_s3) : 1'b1;
    if (pop && buf_valid) begin
      n.txd = buf_bit;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_wr_ready = (r.gap == 4'h0);
  assign o_osc_ready = r.osc_seen;
  // radio use gated on lock flag
  assign o_pll_locked = r.lock_s2;
  assign ifc.serial_tx_data_pin = r.txd;
  assign ifc.reg_wr_toggle = r.wr_tgl;
  assign ifc.reg_addr = r.addr;
  assign ifc.reg_data = r.data;
endmodule
`default_nettype wire

// *** tb/srcb_asserts.sv ***
// Pin-level assertions between the device and host ends
`timescale 1ns/1ps
`default_nettype none
`include "srcb_cfg.svh"
module srcb_asserts #(
  parameter int HOLD_CYC = 48,
  parameter int LOCK_MIN = 74
) (
  input wire logic i_clk,                         // System clock
  input wire logic i_rst,                         // Async reset, high
  input wire logic general_pin_five,              // Reference output
  input wire logic lock_pin,                      // Lock flag
  input wire logic bit_clock_pin,                 // Bit clock
  input wire logic serial_tx_data_pin,            // Transmit bit
  input wire logic reg_wr_toggle,                 // Write strobe
  input wire logic [`SRCB_ADDR_W-1:0] reg_addr,   // Write address
  input wire logic [7:0] reg_data                 // Write data
);
  logic [7:0] up_r;
  logic [3:0] gap_r;
  logic tog_r;
  logic shaped_r;
  logic [2:0] mode_r;
  logic [2:0] sel_r;
  // Shadow of the written settings, snooped from the link
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_r <= 8'h00;
      gap_r <= 4'h0;
      tog_r <= 1'b0;
      shaped_r <= 1'b0;
      mode_r <= `SRCB_MODE_STDBY;
      sel_r <= 3'h0;
    end else begin
      tog_r <= reg_wr_toggle;
      if (up_r != 8'hFF) up_r <= up_r + 8'h01;
      if (gap_r != 4'hF) gap_r <= gap_r + 4'h1;
      if (reg_wr_toggle != tog_r) begin
        gap_r <= 4'h0;
        if (reg_addr == `SRCB_A_OPMODE) mode_r <= reg_data[4:2];
        if (reg_addr == `SRCB_A_DATAMOD) shaped_r <= reg_data[6] && (reg_data[1:0] != 2'h0);
        if (reg_addr == `SRCB_A_PINMAP2) sel_r <= reg_data[2:0];
      end
    end
  end
  wire logic quiet = gap_r > 4'h8;
  wire logic awake = mode_r != `SRCB_MODE_SLEEP;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr;
    $changed(reg_wr_toggle);
  endsequence
  sequence s_hold;
    ($stable(reg_addr) && $stable(reg_data) && $stable(reg_wr_toggle)) [*5];
  endsequence
  sequence s_div4;
    general_pin_five ##1 !general_pin_five [*2];
  endsequence
  chk_ref_held_off: assert property (up_r < HOLD_CYC |-> !general_pin_five)
    else $error("reference output before oscillator ready");
  chk_lock_not_early: assert property (up_r < LOCK_MIN |-> !lock_pin)
    else $error("lock before calibration and lock time");
  chk_lock_fall_cause: assert property ($fell(lock_pin) |-> gap_r < 4'hC)
    else $error("lock dropped without a setting change");
  chk_wr_hold: assert property (s_wr |=> s_hold)
    else $error("write address or data did not stand");
  chk_bclk_idle: assert property (quiet && !shaped_r |-> !bit_clock_pin)
    else $error("bit clock outside shaped mode");
  chk_data_on_bclk: assert property (
    quiet && shaped_r && $changed(serial_tx_data_pin) |-> $past(bit_clock_pin, 2))
    else $error("shaped data changed away from bit clock rise");
  chk_ref_div_two: assert property (
    quiet && awake && up_r > HOLD_CYC + 6 && sel_r == 3'h0 |-> $changed(general_pin_five))
    else $error("reference not divided by two");
  chk_ref_div_four: assert property (
    quiet && awake && sel_r == 3'h1 && $rose(general_pin_five) |=> s_div4)
    else $error("reference not divided by four");
  chk_ref_sel_off: assert property (
    quiet && sel_r == `SRCB_REFSEL_OFF |-> !general_pin_five)
    else $error("reference output not off");
  chk_sleep_stops: assert property (quiet && !awake |-> $stable(general_pin_five))
    else $error("reference output runs in sleep");
endmodule
`default_nettype wire

// *** tb/srcb_tb.sv ***
// Self-checking bench joining the device and host ends
`timescale 1ns/1ps
`default_nettype none
`include "srcb_cfg.svh"
module srcb_tb;
  localparam int OSC = 50;
  // Selectors for the watched outputs
  localparam int W_OSC = 0, W_REF = 1, W_CRS = 2, W_WRR = 3;
  localparam int W_BITR = 4, W_PLL = 5, W_LCK = 6, W_BCLK = 7;
  logic clk, rst, wr_valid, bit_valid, bit_val, sync_tx, wr_ready, bit_ready;
  logic osc_ready, locked, ext_ref, coarse, pll_lock, tx_on, rx_on, mod_bit, bclk, refo, tick;
  logic [6:0] wr_addr;
  logic [7:0] wr_data, hi, mid, bits;
  logic [23:0] carrier, prev;
  logic [7:0] ev [4] = '{8'h10, 8'hEF, 8'hFF, 8'h00};
  int errors, checks_done, p;
  time t0;
  srcb_if ifc();
  assign bclk = ifc.bit_clock_pin;
  assign refo = ifc.general_pin_five;
  srcb_device i_srcb_device (.i_clk(clk), .i_rst(rst), .ifc(ifc), .o_carrier_word(carrier),
    .o_ext_ref(ext_ref), .o_coarse_done(coarse), .o_pll_lock(pll_lock), .o_tx_on(tx_on),
    .o_rx_on(rx_on), .o_mod_bit(mod_bit), .o_bit_tick(tick));
  srcb_host i_srcb_host (.i_clk(clk), .i_rst(rst), .ifc(ifc), .i_wr_valid(wr_valid),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_bit_valid(bit_valid),
    .i_bit(bit_val), .o_bit_ready(bit_ready), .i_sync_tx(sync_tx), .o_osc_ready(osc_ready),
    .o_pll_locked(locked));
  srcb_asserts #(.HOLD_CYC(OSC - 2), .LOCK_MIN(74)) i_chk (.i_clk(clk), .i_rst(rst),
    .general_pin_five(ifc.general_pin_five), .lock_pin(ifc.lock_pin),
    .bit_clock_pin(ifc.bit_clock_pin), .serial_tx_data_pin(ifc.serial_tx_data_pin),
    .reg_wr_toggle(ifc.reg_wr_toggle), .reg_addr(ifc.reg_addr), .reg_data(ifc.reg_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic int ref_period(input int s);
    return 1 << (s + 1);
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic probe(input int w);
    logic [7:0] seen;
    seen = {bclk, locked, pll_lock, bit_ready, wr_ready, coarse, refo, osc_ready};
    return seen[w];
  endfunction
  task automatic wait_for(input int w, input logic v);
    int k;
    k = 0;
    while (probe(w) !== v) begin
      @(posedge clk);
      k++;
      if (k > 9000) begin
        errors++;
        $display("FAIL %0t wait ran out", $time);
        conclude();
      end
    end
  endtask
  task automatic period(input int w, output int q);
    wait_for(w, 1'b0);
    wait_for(w, 1'b1);
    t0 = $time;
    wait_for(w, 1'b0);
    wait_for(w, 1'b1);
    q = int'(($time - t0) / 40);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wait_for(W_WRR, 1'b1);
    wr_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic push(input logic b);
    bit_valid <= 1'b1;
    bit_val <= b;
    @(posedge clk);
    wait_for(W_BITR, 1'b1);
    bit_valid <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    rst = 1'b1;
    {wr_valid, bit_valid, bit_val, sync_tx, wr_addr, wr_data} = '0;
    p = $urandom(26269);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t0 = $time;
    prev = `SRCB_RST_FRF;
    check(carrier, prev);
    wait_for(W_OSC, 1'b1);
    check(($time - t0) / 40 >= OSC, 1'b1);
    period(W_REF, p);
    check(24'(p), 24'd2);
    wait_for(W_CRS, 1'b1);
    $display("test startup done");
    for (int r = 0; r < 3; r++) begin
      hi = 8'($urandom);
      mid = 8'($urandom);
      wr(`SRCB_A_FRF_HI, hi);
      wr(`SRCB_A_FRF_MID, mid);
      repeat (8) @(posedge clk);
      check(carrier, prev);
      wr(`SRCB_A_FRF_LO, 8'(r * 85));
      repeat (6) @(posedge clk);
      prev = {hi, mid, 8'(r * 85)};
      check(carrier, prev);
    end
    foreach (ev[i]) begin
      wr(`SRCB_A_EXTREF, ev[i]);
      repeat (6) @(posedge clk);
      check(ext_ref, ev[i][4]);
    end
    wr(7'h7F, 8'hFF);
    repeat (6) @(posedge clk);
    check({carrier[23:1], ext_ref}, {prev[23:1], 1'b0});
    $display("test registers done");
    t0 = $time;
    wr(`SRCB_A_OPMODE, {3'h0, `SRCB_MODE_TX, 2'h0});
    wait_for(W_PLL, 1'b1);
    p = int'(($time - t0) / 40);
    check(p >= 15 && p <= 24, 1'b1);
    check({tx_on, rx_on}, 2'b10);
    wait_for(W_LCK, 1'b1);
    wr(`SRCB_A_FRF_LO, 8'h55);
    wait_for(W_PLL, 1'b0);
    wait_for(W_PLL, 1'b1);
    check(carrier, {prev[23:8], 8'h55});
    wr(`SRCB_A_OPMODE, {3'h0, `SRCB_MODE_RX, 2'h0});
    repeat (30) @(posedge clk);
    check({tx_on, rx_on}, 2'b01);
    $display("test lock done");
    wr(`SRCB_A_DATAMOD, 8'h40);
    bits = 8'($urandom) ^ 8'hAA;
    for (int k = 0; k < 8; k++) begin
      push(bits[k]);
      repeat (5) @(posedge clk);
      check(mod_bit, bits[k]);
    end
    $display("test plain stream done");
    wr(`SRCB_A_BR_HI, 8'h00);
    wr(`SRCB_A_BR_LO, 8'h14);
    sync_tx <= 1'b1;
    wr(`SRCB_A_DATAMOD, 8'h41);
    period(W_BCLK, p);
    period(W_BCLK, p);
    check(24'(p), 24'd20);
    // Two whole bit periods give two bit ticks
    p = 0;
    repeat (40) begin
      @(posedge clk);
      p += int'(tick);
    end
    check(24'(p), 24'd2);
    bits = 8'($urandom);
    repeat (4) @(posedge clk);
    push(bits[0]);
    push(bits[1]);
    check(bit_ready, 1'b0);
    for (int k = 1; k < 7; k++) begin
      wait_for(W_BCLK, 1'b0);
      wait_for(W_BCLK, 1'b1);
      repeat (4) @(posedge clk);
      if (k > 1) check(mod_bit, bits[k-2]);
      push(bits[k+1]);
    end
    wr(`SRCB_A_BR_LO, 8'h18);
    for (int k = 0; k < 3; k++) begin
      period(W_BCLK, p);
      check(p == 20 || p == 24, 1'b1);
    end
    check(24'(p), 24'd24);
    $display("test shaped stream done");
    for (int s = 0; s < 3; s++) begin
      wr(`SRCB_A_PINMAP2, 8'(s));
      repeat (10) @(posedge clk);
      period(W_REF, p);
      check(24'(p), 24'(ref_period(s)));
    end
    wr(`SRCB_A_PINMAP2, 8'h07);
    repeat (10) @(posedge clk);
    check(refo, 1'b0);
    wr(`SRCB_A_PINMAP2, 8'h00);
    wr(`SRCB_A_OPMODE, {3'h0, `SRCB_MODE_SLEEP, 2'h0});
    repeat (10) @(posedge clk);
    check(pll_lock, 1'b0);
    bits[0] = refo;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      check(refo, bits[0]);
    end
    $display("test reference done");
    conclude();
  end
endmodule
`default_nettype wire
